// >>> design/abs_restore_top.sv
// absolute position restore block with apb register access, completion flags and brake hold
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`include "abs_restore_map.svh"
module abs_restore_top #(
  parameter int unsigned SERVO_DROP_CYCLES = `SERVO_DROP_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  axis_op_busy,
  output logic [3:0]       axis_restoring,
  output logic [3:0]       servo_on_out,
  output logic             brake_out,
  output logic             done_out,
  output logic             error_out,
  output logic             irq
);
  import abs_restore_pkg::*;

  // ************************************************
  // state
  // ************************************************
  logic [2:0]  in_word, next_in_word;
  logic [15:0] status_word, next_status_word;
  logic [15:0] completion, next_completion;
  logic        done, next_done;
  logic        error, next_error;
  logic        pending, next_pending;
  logic        pend_err, next_pend_err;
  logic [2:0]  irq_status, next_irq_status;
  logic [2:0]  irq_mask, next_irq_mask;
  logic [15:0] scale, next_scale;
  logic [2:0]  axes, next_axes;
  logic [2:0]  pos_sel, next_pos_sel;
  logic [3:0]  restored, next_restored;
  logic [2:0]  variant, next_variant;
  axis_t       cur_axis, next_cur_axis;
  logic        axis_valid, next_axis_valid;
  logic        tamper, next_tamper;
  logic        exec, next_exec;
  logic [31:0] rdata, next_rdata;
  logic        slverr, next_slverr;
  logic [20:0] brake_cnt, next_brake_cnt;

  logic        setup;
  logic        wr;
  logic [2:0]  req_var;
  logic [2:0]  req_var_m1;
  axis_t       req_axis;
  logic        req_ok;
  logic [31:0] pos_word;
  logic        mem_wr;

  restore_if rif ();

  restore_engine u_engine (
    .pclk    (pclk),
    .presetn (presetn),
    .rif     (rif.engine)
  );

  position_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (mem_wr),
    .wr_axis (cur_axis),
    .wr_data (rif.position),
    .rd_addr (pos_sel),
    .rd_data (pos_word)
  );

  // ************************************************
  // bus decode
  // ************************************************
  assign setup      = psel & ~penable;
  assign wr         = psel & penable & pwrite;
  assign req_var    = pwdata[2:0];
  assign req_var_m1 = req_var - 3'h1;
  assign req_axis   = req_var_m1[1:0];
  assign req_ok     = (req_var != 3'h0) && (req_var <= `AXIS_MAX) && (req_var <= axes);
  assign mem_wr     = rif.finish && (rif.code == 16'h0000);

  assign rif.exec        = exec;
  assign rif.axis        = cur_axis;
  assign rif.axis_valid  = axis_valid;
  assign rif.in_word     = in_word;
  assign rif.status_zero = (status_word == 16'h0000);
  assign rif.tamper      = tamper;
  assign rif.scale       = scale;

  // ************************************************
  // registers and completion handling
  // ************************************************
  always_comb
  begin
    next_in_word     = in_word;
    next_status_word = status_word;
    next_completion  = completion;
    next_done        = done;
    next_error       = error;
    next_pending     = pending;
    next_pend_err    = pend_err;
    next_irq_status  = irq_status;
    next_irq_mask    = irq_mask;
    next_scale       = scale;
    next_axes        = axes;
    next_pos_sel     = pos_sel;
    next_restored    = restored;
    next_variant     = variant;
    next_cur_axis    = cur_axis;
    next_axis_valid  = axis_valid;
    next_tamper      = tamper;
    next_exec        = 1'b0;
    next_rdata       = rdata;
    next_slverr      = slverr;
    if (setup)
    begin
      next_rdata  = 32'h0;
      next_slverr = 1'b0;
      case (paddr)
        `OFF_EXEC:        next_rdata[2:0] = variant;
        `OFF_IN_WORD:     next_rdata[2:0] = in_word;
        `OFF_OUT_WORD:    next_rdata[2:0] = rif.out_word;
        `OFF_STATUS_WORD: next_rdata[15:0] = status_word;
        `OFF_COMPLETION:  next_rdata[15:0] = completion;
        `OFF_FLAGS:       next_rdata[11:0] = {axis_restoring, restored, pending, rif.busy, error, done};
        `OFF_END_SCAN:    next_rdata = 32'h0;
        `OFF_IRQ_STATUS:  next_rdata[2:0] = irq_status;
        `OFF_IRQ_MASK:    next_rdata[2:0] = irq_mask;
        `OFF_UNIT_SCALE:  next_rdata[15:0] = scale;
        `OFF_AXIS_CFG:    next_rdata[2:0] = axes;
        `OFF_POS_SEL:     next_rdata[2:0] = pos_sel;
        `OFF_POS_DATA:    next_rdata = pos_word;
        default:          next_slverr = 1'b1;
      endcase
    end
    if (wr)
    begin
      case (paddr)
        `OFF_EXEC:
        begin
          if (!rif.busy)
          begin
            if (req_ok && axis_op_busy[req_axis])
              next_irq_status[`IRQ_REFUSE] = 1'b1;
            else
            begin
              next_exec       = 1'b1;
              next_variant    = req_var;
              next_cur_axis   = req_axis;
              next_axis_valid = req_ok;
            end
          end
          else if (req_var == variant)
            next_exec = 1'b1;
          else
            next_irq_status[`IRQ_REFUSE] = 1'b1;
        end
        `OFF_IN_WORD:     next_in_word = pwdata[2:0];
        `OFF_STATUS_WORD:
        begin
          next_status_word = pwdata[15:0];
          if (rif.busy && (pwdata[15:0] != status_word))
            next_tamper = 1'b1;
        end
        `OFF_END_SCAN:
        begin
          next_done    = pending;
          next_error   = pending & pend_err;
          next_pending = 1'b0;
        end
        `OFF_IRQ_STATUS:  next_irq_status = irq_status & ~pwdata[2:0];
        `OFF_IRQ_MASK:    next_irq_mask = pwdata[2:0];
        `OFF_UNIT_SCALE:  next_scale = pwdata[15:0];
        `OFF_AXIS_CFG:    next_axes = pwdata[2:0];
        `OFF_POS_SEL:     next_pos_sel = pwdata[2:0];
        default:          next_in_word = in_word;
      endcase
    end
    // engine events come last so they win over a same-cycle clear
    if (rif.started)
    begin
      next_status_word = `STATUS_BUSY;
      next_tamper      = 1'b0;
    end
    if (rif.finish)
    begin
      next_completion  = rif.code;
      next_status_word = 16'h0000;
      next_tamper      = 1'b0;
      next_pending     = 1'b1;
      next_pend_err    = (rif.code != 16'h0000);
      next_irq_status[`IRQ_DONE] = 1'b1;
      if (rif.code != 16'h0000)
        next_irq_status[`IRQ_ERR] = 1'b1;
      else
        next_restored[cur_axis] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_word     <= 3'h0;
      status_word <= 16'h0000;
      completion  <= 16'h0000;
      done        <= 1'b0;
      error       <= 1'b0;
      pending     <= 1'b0;
      pend_err    <= 1'b0;
      irq_status  <= 3'h0;
      irq_mask    <= 3'h0;
      scale       <= `SCALE_RESET;
      axes        <= `AXES_RESET;
      pos_sel     <= 3'h0;
      restored    <= 4'h0;
      variant     <= 3'h0;
      cur_axis    <= 2'h0;
      axis_valid  <= 1'b0;
      tamper      <= 1'b0;
      exec        <= 1'b0;
      rdata       <= 32'h0;
      slverr      <= 1'b0;
    end
    else
    begin
      in_word     <= next_in_word;
      status_word <= next_status_word;
      completion  <= next_completion;
      done        <= next_done;
      error       <= next_error;
      pending     <= next_pending;
      pend_err    <= next_pend_err;
      irq_status  <= next_irq_status;
      irq_mask    <= next_irq_mask;
      scale       <= next_scale;
      axes        <= next_axes;
      pos_sel     <= next_pos_sel;
      restored    <= next_restored;
      variant     <= next_variant;
      cur_axis    <= next_cur_axis;
      axis_valid  <= next_axis_valid;
      tamper      <= next_tamper;
      exec        <= next_exec;
      rdata       <= next_rdata;
      slverr      <= next_slverr;
    end
  end

  // ************************************************
  // brake hold after the exchange
  // ************************************************
  always_comb
  begin
    next_brake_cnt = brake_cnt;
    if (rif.finish)
      next_brake_cnt = SERVO_DROP_CYCLES[20:0];
    else if (brake_cnt != 21'h0)
      next_brake_cnt = brake_cnt - 21'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      brake_cnt <= 21'h0;
    else
      brake_cnt <= next_brake_cnt;
  end

  // ************************************************
  // outputs
  // ************************************************
  always_comb
  begin
    axis_restoring = 4'h0;
    if (rif.busy)
      axis_restoring[cur_axis] = 1'b1;
  end

  assign servo_on_out = restored & ~axis_restoring;
  // finish covers the cycle before the hold counter loads, so the brake never dips
  assign brake_out    = rif.busy | rif.finish | (brake_cnt != 21'h0);
  assign done_out     = done;
  assign error_out    = error;
  assign irq          = |(irq_status & irq_mask);
  assign prdata       = rdata;
  assign pready       = 1'b1;
  assign pslverr      = slverr & psel & penable;
endmodule : abs_restore_top

// >>> design/abs_restore_map.svh
// offsets, field positions, reset values and timing counts of the position restore block
// Contract
// - read the amplifier position, scale to user units, store as current and feed value
// - the variant selects one axis; variants one to four map to axes one to four
// - done rises at end-of-scan after completion and falls at the next end-of-scan
// - error stays low on success and pulses with done on failure
// - restore once after every reset; servo-on stays off until restoration completes
// - servo-on may drop during restoration; a brake output is driven meanwhile
// - refuse a second operation on a busy axis; other axes stay free (the block refuses any other variant while one restore runs)
// - a nonzero status word at exchange start finishes with code 1860H
// - a status word changed during the exchange finishes with code 1861H
// - an axis the module does not have finishes with code 1865H
// - the completion word holds zero on success, else the error code
// - output word bit 0 servo-on, bit 1 transfer mode, bit 2 position request
// - status word is zero at start, nonzero during the exchange, zero when done
`ifndef ABS_RESTORE_MAP_SVH
`define ABS_RESTORE_MAP_SVH

`define OFF_EXEC        12'h000
`define OFF_IN_WORD     12'h004
`define OFF_OUT_WORD    12'h008
`define OFF_STATUS_WORD 12'h00C
`define OFF_COMPLETION  12'h010
`define OFF_FLAGS       12'h014
`define OFF_END_SCAN    12'h018
`define OFF_IRQ_STATUS  12'h01C
`define OFF_IRQ_MASK    12'h020
`define OFF_UNIT_SCALE  12'h024
`define OFF_AXIS_CFG    12'h028
`define OFF_POS_SEL     12'h02C
`define OFF_POS_DATA    12'h030

`define IN_DATA0  0
`define IN_DATA1  1
`define IN_READY  2
`define OUT_SERVO 0
`define OUT_MODE  1
`define OUT_REQ   2
`define IRQ_DONE   0
`define IRQ_ERR    1
`define IRQ_REFUSE 2

`define ERR_STATUS_START   16'h1860
`define ERR_STATUS_CHANGED 16'h1861
`define ERR_BAD_AXIS       16'h1865
`define STATUS_BUSY        16'h0001

`define AXIS_MAX      3'h4
`define AXES_RESET    3'h4
`define SCALE_RESET   16'h0001
`define LAST_CHUNK    4'hF

`define CLK_HZ            20000000
`define SERVO_DROP_MS     60
`define SERVO_DROP_CYCLES (`SERVO_DROP_MS * (`CLK_HZ / 1000))

`endif

// >>> design/abs_restore_pkg.sv
// types shared by the position restore block
package abs_restore_pkg;
  typedef logic [1:0]  axis_t;
  typedef logic [15:0] code_t;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_READY, ST_WAIT_LOW, ST_WAIT_HIGH} restore_state_t;
endpackage : abs_restore_pkg

// >>> design/restore_if.sv
// carrier between the register side and the handshake engine
`timescale 1ns/1ns
interface restore_if;
  logic                  exec;
  abs_restore_pkg::axis_t axis;
  logic                  axis_valid;
  logic [2:0]            in_word;
  logic                  status_zero;
  logic                  tamper;
  logic [15:0]           scale;
  logic [2:0]            out_word;
  logic                  busy;
  logic                  started;
  logic                  finish;
  abs_restore_pkg::code_t code;
  logic [31:0]           position;

  modport top (output exec, axis, axis_valid, in_word, status_zero, tamper, scale,
               input out_word, busy, started, finish, code, position);
  modport engine (input exec, axis, axis_valid, in_word, status_zero, tamper, scale,
                  output out_word, busy, started, finish, code, position);
endinterface : restore_if

// >>> design/position_mem.sv
// current and feed position words of four axes, registered read
`timescale 1ns/1ns
module position_mem (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   wr_en,
  input  wire abs_restore_pkg::axis_t wr_axis,
  input  wire logic [31:0]            wr_data,
  input  wire logic [2:0]             rd_addr,
  output logic [31:0]                 rd_data
);
  import abs_restore_pkg::*;

  logic [31:0] mem [0:7];

  // both words of an axis take the same value in one write
  always_ff @(posedge pclk)
  begin
    if (wr_en)
    begin
      mem[{wr_axis, 1'b0}] <= wr_data;
      mem[{wr_axis, 1'b1}] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rd_data <= 32'h0;
    else
      rd_data <= mem[rd_addr];
  end
endmodule : position_mem

// >>> design/restore_engine.sv
// handshake engine that walks the amplifier exchange one step per execution
`timescale 1ns/1ns
`include "abs_restore_map.svh"
module restore_engine (
  input wire logic  pclk,
  input wire logic  presetn,
  restore_if.engine rif
);
  import abs_restore_pkg::*;

  restore_state_t state, next_state;
  logic [3:0]     cnt, next_cnt;
  logic [31:0]    shift, next_shift;
  logic [31:0]    position, next_position;
  logic [2:0]     out_word, next_out_word;
  logic           finish, next_finish;
  logic           started, next_started;
  code_t          code, next_code;
  logic [47:0]    product;
  logic           ready;

  assign ready = rif.in_word[`IN_READY];

  always_comb
  begin
    next_state    = state;
    next_cnt      = cnt;
    next_shift    = shift;
    next_position = position;
    next_out_word = out_word;
    next_code     = code;
    next_finish   = 1'b0;
    next_started  = 1'b0;
    product       = 48'h0;
    if (rif.exec)
    begin
      if (state == ST_IDLE)
      begin
        if (!rif.axis_valid)
        begin
          next_code   = `ERR_BAD_AXIS;
          next_finish = 1'b1;
        end
        else if (!rif.status_zero)
        begin
          next_code   = `ERR_STATUS_START;
          next_finish = 1'b1;
        end
        else
        begin
          next_out_word = 3'h0;
          next_out_word[`OUT_MODE] = 1'b1;
          next_cnt      = 4'h0;
          next_started  = 1'b1;
          next_state    = ST_WAIT_READY;
        end
      end
      else if (rif.tamper)
      begin
        next_code     = `ERR_STATUS_CHANGED;
        next_finish   = 1'b1;
        next_out_word = 3'h0;
        next_state    = ST_IDLE;
      end
      else
      begin
        case (state)
          ST_WAIT_READY, ST_WAIT_HIGH:
          begin
            if (ready)
            begin
              next_out_word[`OUT_REQ] = 1'b1;
              next_state = ST_WAIT_LOW;
            end
          end
          ST_WAIT_LOW:
          begin
            if (!ready)
            begin
              next_shift = {shift[29:0], rif.in_word[`IN_DATA1], rif.in_word[`IN_DATA0]};
              next_out_word[`OUT_REQ] = 1'b0;
              if (cnt == `LAST_CHUNK)
              begin
                product       = next_shift * rif.scale;
                next_position = product[31:0];
                next_code     = 16'h0000;
                next_finish   = 1'b1;
                next_out_word = 3'h0;
                next_out_word[`OUT_SERVO] = 1'b1;
                next_state    = ST_IDLE;
              end
              else
              begin
                next_cnt   = cnt + 4'h1;
                next_state = ST_WAIT_HIGH;
              end
            end
          end
          default:
            next_state = ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state    <= ST_IDLE;
      cnt      <= 4'h0;
      shift    <= 32'h0;
      position <= 32'h0;
      out_word <= 3'h0;
      code     <= 16'h0000;
      finish   <= 1'b0;
      started  <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      cnt      <= next_cnt;
      shift    <= next_shift;
      position <= next_position;
      out_word <= next_out_word;
      code     <= next_code;
      finish   <= next_finish;
      started  <= next_started;
    end
  end

  assign rif.out_word = out_word;
  assign rif.busy     = (state != ST_IDLE);
  assign rif.started  = started;
  assign rif.finish   = finish;
  assign rif.code     = code;
  assign rif.position = position;
endmodule : restore_engine

// >>> verification/abs_restore_props.sv
// port checker of the position restore block
`timescale 1ns/1ns
module abs_restore_props #(
  parameter int unsigned SERVO_DROP_CYCLES = 20
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [3:0]  axis_restoring,
  input wire logic [3:0]  servo_on_out,
  input wire logic        brake_out,
  input wire logic        done_out,
  input wire logic        error_out,
  input wire logic        irq
);
  logic        exec_wr;
  logic        scan_wr;
  logic [31:0] cnt;
  logic [31:0] next_cnt;

  assign exec_wr = psel && penable && pwrite && paddr == 12'h000;
  assign scan_wr = psel && penable && pwrite && paddr == 12'h018;

  // cycles since the engine went idle, stopping at SERVO_DROP_CYCLES, zero until the first restore
  always_comb
  begin
    next_cnt = cnt;
    if (|axis_restoring)
      next_cnt = 32'h1;
    else if (cnt != 32'h0 && cnt < SERVO_DROP_CYCLES)
      next_cnt = cnt + 32'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt <= 32'h0;
    else
      cnt <= next_cnt;

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access phase");
  a_unmapped_read: assert property (psel && penable && paddr == 12'h034 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not flagged");
  a_done_scan: assert property ($changed(done_out) |-> $past(scan_wr))
    else $error("done moved outside end of scan");
  a_error_with_done: assert property (error_out |-> done_out)
    else $error("error without done");
  a_servo_off_busy: assert property ((servo_on_out & axis_restoring) == 4'h0)
    else $error("servo on while restoring");
  a_one_axis: assert property ($onehot0(axis_restoring))
    else $error("more than one axis restoring");
  a_brake_busy: assert property (|axis_restoring |-> brake_out)
    else $error("brake off while restoring");
  a_brake_hold: assert property (cnt != 32'h0 && cnt < SERVO_DROP_CYCLES |-> brake_out)
    else $error("brake released too early");
  a_start_cause: assert property ($rose(|axis_restoring) |-> $past(exec_wr) || $past(exec_wr, 2))
    else $error("restore started without execution");

  c_done: cover property (done_out && !error_out);
  c_error: cover property (error_out);
  c_busy: cover property (|axis_restoring && irq);
endmodule : abs_restore_props

bind abs_restore_top abs_restore_props #(.SERVO_DROP_CYCLES(SERVO_DROP_CYCLES)) u_props (.*);

// >>> verification/servo_amp_model.sv
// absolute encoder amplifier answering the three point handshake
`timescale 1ns/1ns
module servo_amp_model (
  input  wire logic [2:0]  cmd,
  input  wire logic        controller_ready_out,
  input  wire logic [31:0] position,
  output logic [2:0]       sig
);
  int         idx = 0;
  logic [1:0] held = 2'b01;

  // next chunk after each request, restart when transfer mode drops
  always @(negedge cmd[2] or negedge cmd[1])
    idx = cmd[1] ? idx + 1 : 0;

  always @(posedge cmd[2])
    held = position[31 - 2 * idx -: 2];

  // ready while in transfer mode, not requested and controller_ready_out low; data only while requested
  always_comb
  begin
    sig[2]   = cmd[1] && !cmd[2] && !controller_ready_out;
    sig[1:0] = (cmd[1] && cmd[2]) ? position[31 - 2 * idx -: 2] : ~held;
  end
endmodule : servo_amp_model

// >>> verification/tb_abs_restore_top.sv
// self-checking bench of the position restore block
`timescale 1ns/1ns
module tb_abs_restore_top;
  logic        pclk, presetn, psel, penable, pwrite, pslverr, pready, perr;
  logic        brake_out, done_out, error_out, irq, controller_ready_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pos, r;
  logic [3:0]  axis_op_busy, axis_restoring, servo_on_out;
  logic [2:0]  cmd, sig;
  int          n_fail, total_checks;

  abs_restore_top #(.SERVO_DROP_CYCLES(20)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .axis_op_busy(axis_op_busy), .axis_restoring(axis_restoring), .servo_on_out(servo_on_out),
    .brake_out(brake_out), .done_out(done_out), .error_out(error_out), .irq(irq));
  servo_amp_model amp (.cmd(cmd), .controller_ready_out(controller_ready_out), .position(pos), .sig(sig));

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ****
  // bus and compare tasks
  // ****
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_reg(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(r, exp);
  endtask : chk_reg

  task automatic restore(input logic [2:0] v);
    controller_ready_out <= 1'b0;
    wr(12'h00C, 32'h0);
    do
    begin
      apb(12'h008, 1'b0, 32'h0);
      cmd <= r[2:0];
      // let the amplifier answer the new outputs before its bits are copied
      @(posedge pclk);
      wr(12'h004, {29'h0, sig});
      wr(12'h000, {29'h0, v});
      apb(12'h00C, 1'b0, 32'h0);
    end
    while (r !== 32'h0);
    controller_ready_out <= 1'b1;
  endtask : restore

  task automatic complete_run;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  initial
  begin
    #2000000;
    n_fail++;
    complete_run();
  end

  // ****
  // tests
  // ****
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    axis_op_busy = 4'h0;
    cmd = 3'h0;
    controller_ready_out = 1'b1;
    pos = 32'h9ABC1234;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk_reg(12'h028, 32'h4);
    chk_reg(12'h024, 32'h1);
    chk({28'h0, servo_on_out}, 32'h0);
    chk_reg(12'h034, 32'h0);
    chk({31'h0, perr}, 32'h1);
    wr(12'h024, 32'h3);
    wr(12'h020, 32'h7);
    restore(3'h1);
    chk_reg(12'h010, 32'h0);
    chk_reg(12'h008, 32'h1);
    chk({28'h0, servo_on_out}, 32'h1);
    wr(12'h02C, 32'h0);
    chk_reg(12'h030, pos * 32'h3);
    wr(12'h02C, 32'h1);
    chk_reg(12'h030, pos * 32'h3);
    chk_reg(12'h01C, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(12'h018, 32'h0);
    chk({30'h0, error_out, done_out}, 32'h1);
    wr(12'h018, 32'h0);
    chk({30'h0, error_out, done_out}, 32'h0);
    wr(12'h01C, 32'h7);
    chk({31'h0, irq}, 32'h0);
    wr(12'h00C, 32'h5);
    wr(12'h000, 32'h2);
    chk_reg(12'h010, 32'h1860);
    chk_reg(12'h00C, 32'h0);
    wr(12'h018, 32'h0);
    chk({30'h0, error_out, done_out}, 32'h3);
    wr(12'h018, 32'h0);
    wr(12'h028, 32'h2);
    wr(12'h000, 32'h3);
    chk_reg(12'h010, 32'h1865);
    wr(12'h028, 32'h4);
    axis_op_busy <= 4'h8;
    wr(12'h01C, 32'h7);
    wr(12'h000, 32'h4);
    chk_reg(12'h01C, 32'h4);
    axis_op_busy <= 4'h0;
    wr(12'h004, 32'h0);
    wr(12'h000, 32'h2);
    @(posedge pclk);
    chk({28'h0, axis_restoring}, 32'h2);
    chk_reg(12'h014, 32'h21C);
    wr(12'h01C, 32'h7);
    wr(12'h000, 32'h1);
    chk_reg(12'h01C, 32'h4);
    wr(12'h00C, 32'h7);
    wr(12'h000, 32'h2);
    chk_reg(12'h010, 32'h1861);
    chk_reg(12'h008, 32'h0);
    chk({28'h0, servo_on_out}, 32'h1);
    complete_run();
  end
endmodule : tb_abs_restore_top
